// *** verilog/kbc_host_pkg.sv ***
/*
  Constants shared by the keyboard-controller host mailbox and its fast reset pulse unit.
  Assumes a single 125 MHz clock domain with an active-low asynchronous reset.
*/
package kbc_host_pkg;

  localparam logic [7:0] DATA_PORT_ADDR = 8'h60;
  localparam logic [7:0] CMD_PORT_ADDR = 8'h64;
  localparam logic [7:0] FAST_PORT_ADDR = 8'h92;

  localparam int ADDR_BIT_TWO = 2;

  localparam int STS_OUT_FULL_BIT = 0;
  localparam int STS_IN_FULL_BIT = 1;
  localparam int STS_CMD_BIT = 3;
  localparam logic [7:0] STS_RESET = 8'h00;
  localparam logic [7:0] STS_HW_MASK = 8'h0B;

  localparam int FAST_RESET_BIT = 0;
  localparam int FAST_A20_BIT = 1;
  localparam logic [7:0] FAST_PORT_FIXED = 8'h24;
  localparam logic [7:0] FAST_PORT_RESET = 8'h24;

  localparam int CLK_PERIOD_PS = 8000;
  localparam int FAST_RST_DELAY_NS = 500;
  localparam int FAST_RST_WIDTH_NS = 1000;
  localparam int FAST_RST_DELAY_CYC = (FAST_RST_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FAST_RST_WIDTH_CYC = (FAST_RST_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// *** verilog/fast_reset_pulser.sv ***
/*
  Delayed active-low reset pulse generator for the fast reset port bit.
  Assumes the trigger is a one-cycle pulse in the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module fast_reset_pulser
  import kbc_host_pkg::*;
#(
  parameter int DELAY_CYC = FAST_RST_DELAY_CYC,
  parameter int WIDTH_CYC = FAST_RST_WIDTH_CYC
)
(
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic i_fire,
  output logic o_pulse_n
);

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_LOW = 3'b100
  } pstate_t;

  typedef struct packed
  {
    pstate_t st;
    logic [15:0] cnt;
    logic pulse_n;
  } pstate_all_t;

  pstate_all_t s_q;
  pstate_all_t s_d;

  initial
  begin
    if (DELAY_CYC < 1 || DELAY_CYC > 65535 || WIDTH_CYC < 1 || WIDTH_CYC > 65535)
    begin
      $error("fast_reset_pulser: counts out of range");
    end
  end

  always_comb
  begin
    s_d = s_q;
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (i_fire)
        begin
          s_d.st = ST_WAIT;
          s_d.cnt = 16'(DELAY_CYC - 1);
        end
      end
      ST_WAIT:
      begin
        if (s_q.cnt == 16'h0000)
        begin
          s_d.st = ST_LOW;
          s_d.cnt = 16'(WIDTH_CYC - 1);
          s_d.pulse_n = 1'b0;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      ST_LOW:
      begin
        if (s_q.cnt == 16'h0000)
        begin
          s_d.st = ST_IDLE;
          s_d.pulse_n = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      s_q <= '{st: ST_IDLE, cnt: 16'h0000, pulse_n: 1'b1};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_pulse_n = s_q.pulse_n;

endmodule
`default_nettype wire

// *** verilog/kbc_host_port.sv ***
/*
  Host byte mailbox between the system bus and the embedded keyboard controller CPU,
  with the fast A20 and fast CPU reset port.
  Assumes host strobes and embedded-side strobes are one-cycle pulses synchronous to
  I_REF_CLK, and that the system reset meets its minimum width.
*/
// Notes on behaviour
// - Embedded CPU gets two interrupts: input buffer full and timer overflow.
// - Embedded write of output data loads host buffer, sets output full, raises irq.
// - Embedded read of input data returns host byte and clears input full.
// - Status bit0 output full, bit1 input full, bit3 command; others user bits.
// - Reset clears the status register to zero.
// - Status is read-only to host, read/write to embedded CPU.
// - Host write sets command flag from host address bit two.
// - Host write sets input full, raising embedded irq; no pin for it.
// - Host read of output data clears output full.
// - Controller logic runs at 12 MHz derived from 14.318 MHz; here all logic runs on the 125 MHz I_REF_CLK.
// - System reset is only reset source; serial lines return to input.
// - Fast port accessible only while config enable bit two is set.
// - Fast port reads bits 7:6 zero, 5 one, 4:3 zero, 2 one.
// - Fast port bit 1 drives the fast A20 control output.
// - Writing one to bit 0 pulses fast reset low after a delay.
// - Bit 0 must return to zero before another pulse can occur.
// - A20 mask output is OR of fast A20 and controller A20 bit.
// - Reset drives fast A20 control low.
// - Reset drives fast reset high and clears bit 0.
// - Enabled fast pulse ANDs with controller reset, polarity selectable.
// - Open-drain port bit zero drives low, one tristates the pin.
// - Data port write clears command flag; command port write sets it.
// - With flag gating, keyboard irq follows output full only while port bit set.
`timescale 1ns/1ns
`default_nettype none
module kbc_host_port
  import kbc_host_pkg::*;
#(
  parameter int DELAY_CYC = FAST_RST_DELAY_CYC,
  parameter int WIDTH_CYC = FAST_RST_WIDTH_CYC
)
(
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic [7:0] I_HOST_ADDR,
  input wire logic [7:0] I_HOST_WDATA,
  input wire logic I_HOST_WR,
  input wire logic I_HOST_RD,
  output logic [7:0] O_HOST_RDATA,
  input wire logic I_EMB_DATA_WR,
  input wire logic I_EMB_DATA_RD,
  input wire logic I_EMB_STS_WR,
  input wire logic [7:0] I_EMB_WDATA,
  output logic [7:0] O_EMB_IN_DATA,
  output logic [7:0] O_EMB_STATUS,
  input wire logic I_TIMER_OVF,
  output logic O_EMB_IBF_IRQ,
  output logic O_EMB_TIMER_IRQ,
  input wire logic I_EN_FLAGS,
  input wire logic I_KBD_IRQ_PORT_BIT,
  output logic O_KEYBOARD_HOST_IRQ,
  input wire logic I_FAST_PORT_ENABLE_CONFIG,
  input wire logic I_EMBEDDED_A20_PORT_BIT,
  input wire logic I_CONTROLLER_CPU_RESET_N,
  input wire logic I_RESET_OUT_INVERT,
  output logic O_FAST_A20_CONTROL,
  output logic O_FAST_CPU_RESET_N,
  output logic O_CPU_A20_MASK_N,
  output logic O_COMBINED_CPU_RESET_OUT,
  input wire logic I_EMBEDDED_PORT_LINE_SEVEN,
  input wire logic I_LINE_SEVEN_OPEN_DRAIN,
  output logic O_LINE_SEVEN_OUT,
  output logic O_LINE_SEVEN_OE,
  output logic O_KBD_CLOCK_LINE_OE,
  output logic O_KBD_DATA_LINE_OE
);

  typedef struct packed
  {
    logic [7:0] out_data;
    logic [7:0] in_data;
    logic [7:0] status;
    logic [7:0] host_rdata;
    logic kbd_irq;
    logic ibf_irq;
    logic tmr_irq;
    logic fast_a20;
    logic fast_rst_bit;
    logic fire;
    logic a20_mask_n;
    logic fast_rst_n;
    logic comb_rst;
    logic line7_out;
    logic line7_oe;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic pulse_n;

  initial
  begin
    if (DELAY_CYC < 1 || WIDTH_CYC < 1)
    begin
      $error("kbc_host_port: pulse counts must be at least one");
    end
  end

  function automatic logic [7:0] fast_port_view(input logic a20, input logic rst);
    fast_port_view = FAST_PORT_FIXED;
    fast_port_view[FAST_A20_BIT] = a20;
    fast_port_view[FAST_RESET_BIT] = rst;
  endfunction

  fast_reset_pulser #(
    .DELAY_CYC(DELAY_CYC),
    .WIDTH_CYC(WIDTH_CYC)
  ) u_pulser (
    .I_REF_CLK(I_REF_CLK),
    .I_ARST_N(I_ARST_N),
    .i_fire(s_q.fire),
    .o_pulse_n(pulse_n)
  );

  always_comb
  begin
    logic host_data_wr;
    logic host_cmd_wr;
    logic fast_acc;
    host_data_wr = I_HOST_WR && (I_HOST_ADDR == DATA_PORT_ADDR);
    host_cmd_wr = I_HOST_WR && (I_HOST_ADDR == CMD_PORT_ADDR);
    fast_acc = I_FAST_PORT_ENABLE_CONFIG && (I_HOST_ADDR == FAST_PORT_ADDR);
    s_d = s_q;
    s_d.fire = 1'b0;

    // Embedded side may rewrite user bits only; hardware flags keep their own logic.
    if (I_EMB_STS_WR)
    begin
      s_d.status = (I_EMB_WDATA & ~STS_HW_MASK) | (s_q.status & STS_HW_MASK);
    end
    if (I_EMB_DATA_RD)
    begin
      s_d.status[STS_IN_FULL_BIT] = 1'b0;
    end
    if (I_HOST_RD && I_HOST_ADDR == DATA_PORT_ADDR)
    begin
      s_d.status[STS_OUT_FULL_BIT] = 1'b0;
    end
    // Sets come after clears so a same-cycle event is never lost.
    if (I_EMB_DATA_WR)
    begin
      s_d.out_data = I_EMB_WDATA;
      s_d.status[STS_OUT_FULL_BIT] = 1'b1;
    end
    if (host_data_wr || host_cmd_wr)
    begin
      s_d.in_data = I_HOST_WDATA;
      s_d.status[STS_IN_FULL_BIT] = 1'b1;
      s_d.status[STS_CMD_BIT] = I_HOST_ADDR[ADDR_BIT_TWO];
    end

    s_d.host_rdata = s_q.host_rdata;
    if (I_HOST_RD)
    begin
      if (I_HOST_ADDR == DATA_PORT_ADDR)
      begin
        s_d.host_rdata = s_q.out_data;
      end
      else if (I_HOST_ADDR == CMD_PORT_ADDR)
      begin
        s_d.host_rdata = s_q.status;
      end
      else if (fast_acc)
      begin
        s_d.host_rdata = fast_port_view(s_q.fast_a20, s_q.fast_rst_bit);
      end
      else
      begin
        s_d.host_rdata = 8'h00;
      end
    end

    if (I_HOST_WR && fast_acc)
    begin
      s_d.fast_a20 = I_HOST_WDATA[FAST_A20_BIT];
      s_d.fast_rst_bit = I_HOST_WDATA[FAST_RESET_BIT];
      // Only a zero-to-one change fires, so bit 0 must be cleared to re-arm.
      s_d.fire = I_HOST_WDATA[FAST_RESET_BIT] && !s_q.fast_rst_bit;
    end

    s_d.ibf_irq = s_d.status[STS_IN_FULL_BIT];
    s_d.tmr_irq = I_TIMER_OVF;
    if (I_EN_FLAGS)
    begin
      s_d.kbd_irq = s_d.status[STS_OUT_FULL_BIT] && I_KBD_IRQ_PORT_BIT;
    end
    else
    begin
      s_d.kbd_irq = I_KBD_IRQ_PORT_BIT;
    end

    s_d.a20_mask_n = s_d.fast_a20 || I_EMBEDDED_A20_PORT_BIT;
    s_d.fast_rst_n = pulse_n;
    s_d.comb_rst = (I_CONTROLLER_CPU_RESET_N && (pulse_n || !I_FAST_PORT_ENABLE_CONFIG))
      ^ I_RESET_OUT_INVERT;

    s_d.line7_out = 1'b0;
    if (I_LINE_SEVEN_OPEN_DRAIN)
    begin
      s_d.line7_oe = !I_EMBEDDED_PORT_LINE_SEVEN;
    end
    else
    begin
      s_d.line7_out = I_EMBEDDED_PORT_LINE_SEVEN;
      s_d.line7_oe = 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      s_q <= '0;
      s_q.status <= STS_RESET;
      s_q.fast_a20 <= 1'b0;
      s_q.fast_rst_bit <= 1'b0;
      s_q.fast_rst_n <= 1'b1;
      s_q.comb_rst <= 1'b1;
      s_q.a20_mask_n <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign O_HOST_RDATA = s_q.host_rdata;
  assign O_EMB_IN_DATA = s_q.in_data;
  assign O_EMB_STATUS = s_q.status;
  assign O_EMB_IBF_IRQ = s_q.ibf_irq;
  assign O_EMB_TIMER_IRQ = s_q.tmr_irq;
  assign O_KEYBOARD_HOST_IRQ = s_q.kbd_irq;
  assign O_FAST_A20_CONTROL = s_q.fast_a20;
  assign O_FAST_CPU_RESET_N = s_q.fast_rst_n;
  assign O_CPU_A20_MASK_N = s_q.a20_mask_n;
  assign O_COMBINED_CPU_RESET_OUT = s_q.comb_rst;
  assign O_LINE_SEVEN_OUT = s_q.line7_out;
  assign O_LINE_SEVEN_OE = s_q.line7_oe;
  // Serial lines stay released (input) from reset; their protocol lives elsewhere.
  assign O_KBD_CLOCK_LINE_OE = 1'b0;
  assign O_KBD_DATA_LINE_OE = 1'b0;

endmodule
`default_nettype wire

// *** test/kbc_host_port_asserts.sv ***
/*
  Concurrent checks on the mailbox flags and the fast A20 path.
  Assumes it is bound to kbc_host_port and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module kbc_host_port_asserts
  import kbc_host_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic [7:0] I_HOST_ADDR,
  input wire logic [7:0] I_HOST_WDATA,
  input wire logic I_HOST_WR,
  input wire logic I_HOST_RD,
  input wire logic I_EMB_DATA_WR,
  input wire logic I_EMB_DATA_RD,
  input wire logic [7:0] O_EMB_IN_DATA,
  input wire logic [7:0] O_EMB_STATUS,
  input wire logic O_EMB_IBF_IRQ,
  input wire logic I_FAST_PORT_ENABLE_CONFIG,
  input wire logic I_EMBEDDED_A20_PORT_BIT,
  input wire logic O_FAST_A20_CONTROL,
  input wire logic O_CPU_A20_MASK_N
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);
  // The mask may be registered from either side of the A20 flop, so it is judged when steady.
  wire logic a20_in = O_FAST_A20_CONTROL | I_EMBEDDED_A20_PORT_BIT;
  sequence cmd_wr_s;
    I_HOST_WR && I_HOST_ADDR == CMD_PORT_ADDR;
  endsequence
  sequence fast_wr_s;
    I_HOST_WR && I_HOST_ADDR == FAST_PORT_ADDR;
  endsequence
  cmd_write_a: assert property (cmd_wr_s |=> O_EMB_STATUS[3] && O_EMB_STATUS[1] &&
    O_EMB_IN_DATA == $past(I_HOST_WDATA)) else $error("command write wrong");
  data_write_a: assert property (I_HOST_WR && I_HOST_ADDR == DATA_PORT_ADDR
    |=> !O_EMB_STATUS[3] && O_EMB_STATUS[1]) else $error("data write wrong");
  obf_set_a: assert property (I_EMB_DATA_WR |=> O_EMB_STATUS[0])
    else $error("output full not set");
  obf_clear_a: assert property (I_HOST_RD && I_HOST_ADDR == DATA_PORT_ADDR
    && !I_EMB_DATA_WR |=> !O_EMB_STATUS[0]) else $error("output full not cleared");
  ibf_clear_a: assert property (I_EMB_DATA_RD && !I_HOST_WR |=> !O_EMB_STATUS[1])
    else $error("input full not cleared");
  ibf_irq_a: assert property (O_EMB_IBF_IRQ == O_EMB_STATUS[1])
    else $error("input irq differs from flag");
  fast_a20_a: assert property (fast_wr_s and I_FAST_PORT_ENABLE_CONFIG
    |=> O_FAST_A20_CONTROL == $past(I_HOST_WDATA[1])) else $error("fast A20 wrong");
  fast_locked_a: assert property (fast_wr_s and !I_FAST_PORT_ENABLE_CONFIG
    |=> $stable(O_FAST_A20_CONTROL)) else $error("fast port written while off");
  a20_mask_a: assert property ($stable(a20_in) [*3] |-> O_CPU_A20_MASK_N == a20_in)
    else $error("A20 mask wrong");
endmodule
bind kbc_host_port kbc_host_port_asserts u_chk (.I_REF_CLK, .I_ARST_N, .I_HOST_ADDR,
  .I_HOST_WDATA, .I_HOST_WR, .I_HOST_RD, .I_EMB_DATA_WR, .I_EMB_DATA_RD, .O_EMB_IN_DATA,
  .O_EMB_STATUS, .O_EMB_IBF_IRQ, .I_FAST_PORT_ENABLE_CONFIG, .I_EMBEDDED_A20_PORT_BIT,
  .O_FAST_A20_CONTROL, .O_CPU_A20_MASK_N);
`default_nettype wire

// *** test/kbc_host_model.sv ***
/*
  Host processor bus model: one-cycle read or write strobes.
  Assumes read data is registered at the edge that takes the strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module kbc_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial
  begin
    {o_addr, o_wdata, o_wr, o_rd} = '0;
  end
  // Released lines are inverted so a stale address or byte never looks valid.
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge i_clk);
    {o_addr, o_wdata, o_wr, o_rd} <= {a, d, w, !w};
    @(posedge i_clk);
    {o_addr, o_wdata, o_wr, o_rd} <= {~a, ~d, 2'h0};
    #1;
    q = i_rdata;
  endtask
endmodule
`default_nettype wire

// *** test/test_kbc_host_port_fast_a20_reset.sv ***
/*
  Self-checking bench for the host mailbox and fast port.
  Assumes the host bus model and a bound checker beside the design.
*/
`timescale 1ns/1ns
`default_nettype none
module test_kbc_host_port_fast_a20_reset;
  logic I_REF_CLK, I_ARST_N, I_HOST_WR, I_HOST_RD, I_EMB_DATA_WR, I_EMB_DATA_RD, I_EMB_STS_WR;
  logic I_TIMER_OVF, I_EN_FLAGS, I_KBD_IRQ_PORT_BIT, I_FAST_PORT_ENABLE_CONFIG;
  logic I_EMBEDDED_A20_PORT_BIT, I_CONTROLLER_CPU_RESET_N, I_RESET_OUT_INVERT;
  logic I_EMBEDDED_PORT_LINE_SEVEN, I_LINE_SEVEN_OPEN_DRAIN, O_EMB_IBF_IRQ, O_EMB_TIMER_IRQ;
  logic O_KEYBOARD_HOST_IRQ, O_FAST_A20_CONTROL, O_FAST_CPU_RESET_N, O_CPU_A20_MASK_N;
  logic O_COMBINED_CPU_RESET_OUT, O_LINE_SEVEN_OUT, O_LINE_SEVEN_OE, O_KBD_CLOCK_LINE_OE;
  logic O_KBD_DATA_LINE_OE;
  logic [7:0] I_HOST_ADDR, I_HOST_WDATA, O_HOST_RDATA, I_EMB_WDATA, O_EMB_IN_DATA, O_EMB_STATUS;
  logic [7:0] q;
  int failures, checks, n, m, f;
  kbc_host_model h (.i_clk(I_REF_CLK), .i_rdata(O_HOST_RDATA), .o_addr(I_HOST_ADDR),
    .o_wdata(I_HOST_WDATA), .o_wr(I_HOST_WR), .o_rd(I_HOST_RD));
  kbc_host_port #(.DELAY_CYC(2), .WIDTH_CYC(3)) dut (.I_REF_CLK, .I_ARST_N, .I_HOST_ADDR,
    .I_HOST_WDATA, .I_HOST_WR, .I_HOST_RD, .O_HOST_RDATA, .I_EMB_DATA_WR, .I_EMB_DATA_RD,
    .I_EMB_STS_WR, .I_EMB_WDATA, .O_EMB_IN_DATA, .O_EMB_STATUS, .I_TIMER_OVF, .O_EMB_IBF_IRQ,
    .O_EMB_TIMER_IRQ, .I_EN_FLAGS, .I_KBD_IRQ_PORT_BIT, .O_KEYBOARD_HOST_IRQ,
    .I_FAST_PORT_ENABLE_CONFIG, .I_EMBEDDED_A20_PORT_BIT, .I_CONTROLLER_CPU_RESET_N,
    .I_RESET_OUT_INVERT, .O_FAST_A20_CONTROL, .O_FAST_CPU_RESET_N, .O_CPU_A20_MASK_N,
    .O_COMBINED_CPU_RESET_OUT, .I_EMBEDDED_PORT_LINE_SEVEN, .I_LINE_SEVEN_OPEN_DRAIN,
    .O_LINE_SEVEN_OUT, .O_LINE_SEVEN_OE, .O_KBD_CLOCK_LINE_OE, .O_KBD_DATA_LINE_OE);
  // Wide enough that a status byte packed with one flag keeps all nine bits.
  task automatic ck(input string s, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge I_REF_CLK);
    #1;
  endtask
  // Strobes are {data write, data read, status write}.
  task automatic emb(input logic [2:0] s, input logic [7:0] d);
    @(posedge I_REF_CLK);
    {I_EMB_DATA_WR, I_EMB_DATA_RD, I_EMB_STS_WR, I_EMB_WDATA} <= {s, d};
    @(posedge I_REF_CLK);
    {I_EMB_DATA_WR, I_EMB_DATA_RD, I_EMB_STS_WR, I_EMB_WDATA} <= {3'h0, ~d};
    #1;
  endtask
  task automatic hw(input logic [7:0] a, d);
    h.xfer(1'b1, a, d, q);
  endtask
  task automatic hr(input logic [7:0] a);
    h.xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic pulse;
    {n, m, f} = {32'd0, 32'd0, 32'd99};
    for (int i = 0; i < 20; i++)
    begin
      w(1);
      if (!O_FAST_CPU_RESET_N && f == 99)
        f = i;
      n += !O_FAST_CPU_RESET_N;
      m += !O_COMBINED_CPU_RESET_OUT;
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    {I_ARST_N, I_EMB_DATA_WR, I_EMB_DATA_RD, I_EMB_STS_WR, I_TIMER_OVF, I_EN_FLAGS,
      I_KBD_IRQ_PORT_BIT, I_FAST_PORT_ENABLE_CONFIG, I_EMBEDDED_A20_PORT_BIT,
      I_RESET_OUT_INVERT, I_EMBEDDED_PORT_LINE_SEVEN, I_LINE_SEVEN_OPEN_DRAIN} = '0;
    {I_EMB_WDATA, I_CONTROLLER_CPU_RESET_N, I_REF_CLK} = {8'h00, 2'h2};
    forever #4 I_REF_CLK = ~I_REF_CLK;
  end
  initial
  begin
    repeat (2) @(posedge I_REF_CLK);
    I_ARST_N <= 1'b1;
    w(1);
    ck("sts", O_EMB_STATUS, 8'h00);
    ck("a20", O_FAST_A20_CONTROL, 1'b0);
    ck("rst", {O_FAST_CPU_RESET_N, O_COMBINED_CPU_RESET_OUT}, 2'h3);
    ck("oe", {O_KBD_CLOCK_LINE_OE, O_KBD_DATA_LINE_OE}, 2'h0);
    hw(8'h64, 8'hAB);
    ck("sts", O_EMB_STATUS, 8'h0A);
    ck("in", O_EMB_IN_DATA, 8'hAB);
    ck("ibf", O_EMB_IBF_IRQ, 1'b1);
    hr(8'h64);
    ck("hsts", q, 8'h0A);
    emb(3'h2, 8'h00);
    ck("sts", O_EMB_STATUS, 8'h08);
    hw(8'h60, 8'h5C);
    ck("sts", O_EMB_STATUS, 8'h02);
    emb(3'h2, 8'h00);
    emb(3'h1, 8'hFF);
    ck("sts", O_EMB_STATUS, 8'hF4);
    emb(3'h1, 8'h00);
    I_TIMER_OVF <= 1'b1;
    I_EN_FLAGS <= 1'b1;
    I_KBD_IRQ_PORT_BIT <= 1'b1;
    emb(3'h4, 8'h3C);
    w(1);
    ck("tmr", {O_EMB_TIMER_IRQ, O_EMB_IBF_IRQ}, 2'h2);
    ck("sts", {O_EMB_STATUS, O_KEYBOARD_HOST_IRQ}, 8'h03);
    hr(8'h60);
    ck("hdat", q, 8'h3C);
    w(1);
    ck("obf", {O_EMB_STATUS[0], O_KEYBOARD_HOST_IRQ}, 2'h0);
    emb(3'h4, 8'h11);
    I_KBD_IRQ_PORT_BIT <= 1'b0;
    w(2);
    ck("keyboard_host_irq", O_KEYBOARD_HOST_IRQ, 1'b0);
    hw(8'h92, 8'h02);
    hr(8'h92);
    ck("off", {q, O_FAST_A20_CONTROL}, 8'h00);
    hr(8'h70);
    ck("unmap", q, 8'h00);
    I_FAST_PORT_ENABLE_CONFIG <= 1'b1;
    hr(8'h92);
    ck("fp", q, 8'h24);
    hw(8'h92, 8'hFA);
    hr(8'h92);
    ck("fp", q, 8'h26);
    ck("a20", {O_FAST_A20_CONTROL, O_CPU_A20_MASK_N}, 2'h3);
    hw(8'h92, 8'h00);
    w(1);
    ck("a20", {O_FAST_A20_CONTROL, O_CPU_A20_MASK_N}, 2'h0);
    I_EMBEDDED_A20_PORT_BIT <= 1'b1;
    w(2);
    ck("mask", O_CPU_A20_MASK_N, 1'b1);
    hw(8'h92, 8'h01);
    pulse;
    ck("pulse", f >= 2 && n == 3, 1'b1);
    ck("comb", 8'(m), 8'(n));
    hw(8'h92, 8'h01);
    pulse;
    ck("again", 8'(n), 8'h00);
    hw(8'h92, 8'h00);
    hw(8'h92, 8'h01);
    pulse;
    ck("rearm", n >= 3, 1'b1);
    I_CONTROLLER_CPU_RESET_N <= 1'b0;
    w(2);
    ck("comb", O_COMBINED_CPU_RESET_OUT, 1'b0);
    I_RESET_OUT_INVERT <= 1'b1;
    w(2);
    ck("inv", O_COMBINED_CPU_RESET_OUT, 1'b1);
    // Packed {out, oe} per case: push-pull 0 and 1, then open drain 0 and 1.
    for (int i = 0; i < 4; i++)
    begin
      {I_LINE_SEVEN_OPEN_DRAIN, I_EMBEDDED_PORT_LINE_SEVEN} <= 2'(i);
      w(2);
      ck("l7", {O_LINE_SEVEN_OUT, O_LINE_SEVEN_OE}, 2'(8'h1D >> (2 * i)));
    end
    // A second reset mid-run, held 188 cycles, covering 24 periods of 16 MHz.
    @(posedge I_REF_CLK);
    I_ARST_N <= 1'b0;
    repeat (188) @(posedge I_REF_CLK);
    I_ARST_N <= 1'b1;
    w(1);
    ck("sts2", O_EMB_STATUS, 8'h00);
    ck("a202", O_FAST_A20_CONTROL, 1'b0);
    ck("rst2", O_FAST_CPU_RESET_N, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire
